// *** hw/pfsw_defs.svh ***
// constants for the program flash self-write controller
`ifndef PFSW_DEFS_SVH
`define PFSW_DEFS_SVH
`define PFSW_UNLOCK_FIRST   8'h55
`define PFSW_UNLOCK_SECOND  8'haa
`define PFSW_CLK_HZ         50000000
`define PFSW_ERASE_US       4000
`define PFSW_PWRT_US        72000
`define PFSW_ERASE_CYC      ((`PFSW_CLK_HZ / 1000000) * `PFSW_ERASE_US)
`define PFSW_PWRT_CYC       ((`PFSW_CLK_HZ / 1000000) * `PFSW_PWRT_US)
`define PFSW_LAST_SLOT      2'h3
`define PFSW_ROW_LAST       4'h3
`define PFSW_ADDR_MAX       13'h0fff
`define PFSW_CTL_CALIBRATION_SPACE_SELECT     6
`define PFSW_CTL_WRITE_ENABLE_BIT       2
`define PFSW_CTL_WR         1
`define PFSW_CTL_RD         0
`define PFSW_CTL_RSVD_ONE   7
`endif

// *** hw/pfsw_pkg.sv ***
// types for the program flash self-write controller
`default_nettype none
package pfsw_pkg;
	typedef enum logic [2:0] {
		PFSW_IDLE,
		PFSW_RD1,
		PFSW_RD2,
		PFSW_WSET1,
		PFSW_WSET2,
		PFSW_ERASE,
		PFSW_PROG
	} pfsw_state_t;
	typedef struct packed {
		logic [7:0] wdata;
		logic       wr_addr_low;
		logic       wr_addr_high;
		logic       wr_data_low;
		logic       wr_data_high;
		logic       wr_control;
		logic       wr_unlock;
	} pfsw_sfr_wr_t;
	typedef struct packed {
		logic        req;
		logic        erase;
		logic [12:0] addr;
		logic [13:0] data;
		logic        test_space;
	} pfsw_arr_req_t;
endpackage : pfsw_pkg
`default_nettype wire

// *** hw/pfsw_buf.sv ***
// four-word write buffer with registered read port
`default_nettype none
module pfsw_buf
	import pfsw_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        nrst_i,
	input  wire logic        we_i,
	input  wire logic [1:0]  wslot_i,
	input  wire logic [13:0] wdata_i,
	input  wire logic [1:0]  rslot_i,
	output logic      [13:0] rdata_o
);
	logic [13:0] mem [4];
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_slot
			always_ff @(posedge clk_i or negedge nrst_i) begin
				if (!nrst_i)
					mem[g] <= 14'h0000;
				else if (we_i && wslot_i == 2'(g))
					mem[g] <= wdata_i;
			end
		end
	endgenerate
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i)
			rdata_o <= 14'h0000;
		else
			rdata_o <= mem[rslot_i];
	end
endmodule // pfsw_buf
`default_nettype wire

// *** hw/pfsw_ctrl.sv ***
// program flash self-write controller top
`include "pfsw_defs.svh"
`default_nettype none
module pfsw_ctrl
	import pfsw_pkg::*;
#(
	parameter int unsigned ERASE_CYC = `PFSW_ERASE_CYC,
	parameter int unsigned PWRT_CYC  = `PFSW_PWRT_CYC
) (
	input  wire logic          clk_i,
	input  wire logic          nrst_i,
	input  wire pfsw_sfr_wr_t  sfr_wr_i,
	input  wire logic [1:0]    protect_seg_i,
	input  wire logic          serial_prog_i,
	input  wire logic          code_protect_i,
	input  wire logic [13:0]   arr_rdata_i,
	input  wire logic          arr_done_i,
	output pfsw_arr_req_t      arr_req_o,
	output logic [7:0]         flash_addr_low_o,
	output logic [7:0]         flash_addr_high_o,
	output logic [7:0]         flash_data_low_o,
	output logic [7:0]         flash_data_high_o,
	output logic [7:0]         flash_control_o,
	output logic [7:0]         flash_unlock_port_o,
	output logic               discard_instr_o,
	output logic               cpu_stall_o,
	output logic               write_blocked_o
);
	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	pfsw_state_t state_reg, state_next;
	logic [7:0]  addr_lo_reg;
	logic [3:0]  addr_hi_reg;
	logic [13:0] data_reg;
	logic        calibration_space_select_reg, write_enable_bit_reg, wr_reg, rd_reg;
	logic [1:0]  unlock_reg;
	logic [31:0] cnt_reg;
	logic        pwrt_done_reg;
	logic [31:0] pwrt_reg;
	logic [1:0]  prog_slot_reg;
	logic        armed_reg;

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	wire logic [7:0]  wd       = sfr_wr_i.wdata;
	wire logic [12:0] addr_w   = {1'b0, addr_hi_reg, addr_lo_reg};
	wire logic        set_rd   = sfr_wr_i.wr_control && wd[`PFSW_CTL_RD]
		&& !rd_reg && !wr_reg;
	wire logic        set_wr   = sfr_wr_i.wr_control && wd[`PFSW_CTL_WR]
		&& !rd_reg && !wr_reg;
	wire logic        unlocked = unlock_reg == 2'h2;
	// segment map: 0 none, 1 low 1k, 2 low 2k, 3 all protected
	wire logic        seg_prot = (protect_seg_i == 2'h3)
		|| (protect_seg_i == 2'h2 && addr_w < 13'h0800)
		|| (protect_seg_i == 2'h1 && addr_w < 13'h0400);
	// protection ignored while the serial programmer owns the array
	wire logic        prot_hit = seg_prot && !serial_prog_i;
	wire logic        wr_ok    = unlocked && write_enable_bit_reg && pwrt_done_reg
		&& !calibration_space_select_reg && !prot_hit && addr_w <= `PFSW_ADDR_MAX
		&& !(serial_prog_i && code_protect_i);
	wire logic        last_slot = addr_lo_reg[1:0] == `PFSW_LAST_SLOT;
	wire logic        row_erase = addr_lo_reg[3:0] == `PFSW_ROW_LAST;
	wire logic [1:0]  slot      = addr_lo_reg[1:0];
	wire logic        buf_we    = state_reg == PFSW_WSET1 && armed_reg;
	wire logic [13:0] buf_rdata;

	// ----------------------------------------------------------------
	// write buffer
	// ----------------------------------------------------------------
	pfsw_buf u_buf (
		.clk_i   (clk_i),
		.nrst_i  (nrst_i),
		.we_i    (buf_we),
		.wslot_i (slot),
		.wdata_i (data_reg),
		.rslot_i (prog_slot_reg),
		.rdata_o (buf_rdata)
	);

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			PFSW_IDLE: begin
				if (rd_reg)
					state_next = PFSW_RD1;
				else if (wr_reg)
					state_next = PFSW_WSET1;
			end
			PFSW_RD1:   state_next = PFSW_RD2;
			PFSW_RD2:   state_next = PFSW_IDLE;
			PFSW_WSET1: state_next = PFSW_WSET2;
			PFSW_WSET2: begin
				if (armed_reg && last_slot)
					state_next = row_erase ? PFSW_ERASE : PFSW_PROG;
				else
					state_next = PFSW_IDLE;
			end
			PFSW_ERASE: begin
				if (cnt_reg >= ERASE_CYC - 1)
					state_next = PFSW_PROG;
			end
			PFSW_PROG: begin
				if (arr_done_i && prog_slot_reg == 2'h3)
					state_next = PFSW_IDLE;
			end
			default: state_next = PFSW_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_reg <= PFSW_IDLE;
			cnt_reg   <= 32'h0;
			armed_reg <= 1'b0;
			prog_slot_reg <= 2'h0;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= (state_reg == PFSW_ERASE) ? cnt_reg + 32'h1 : 32'h0;
			if (state_reg == PFSW_IDLE && wr_reg)
				armed_reg <= wr_ok;
			if (state_reg == PFSW_WSET2)
				prog_slot_reg <= 2'h0;
			else if (state_reg == PFSW_PROG && arr_done_i)
				prog_slot_reg <= prog_slot_reg + 2'h1;
		end
	end

	// ----------------------------------------------------------------
	// sfr registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			addr_lo_reg <= 8'h00;
			addr_hi_reg <= 4'h0;
			data_reg    <= 14'h0000;
			calibration_space_select_reg  <= 1'b0;
			write_enable_bit_reg    <= 1'b0;
			rd_reg      <= 1'b0;
			wr_reg      <= 1'b0;
			unlock_reg  <= 2'h0;
		end else begin
			if (sfr_wr_i.wr_addr_low)
				addr_lo_reg <= wd;
			if (sfr_wr_i.wr_addr_high)
				addr_hi_reg <= wd[3:0];
			if (state_reg == PFSW_RD2)
				data_reg <= arr_rdata_i;
			else if (sfr_wr_i.wr_data_low)
				data_reg[7:0] <= wd;
			else if (sfr_wr_i.wr_data_high)
				data_reg[13:8] <= wd[5:0];
			if (sfr_wr_i.wr_control) begin
				calibration_space_select_reg <= wd[`PFSW_CTL_CALIBRATION_SPACE_SELECT];
				write_enable_bit_reg   <= wd[`PFSW_CTL_WRITE_ENABLE_BIT];
			end
			// set-only from software, cleared by the sequencer
			if (set_rd)
				rd_reg <= 1'b1;
			else if (state_reg == PFSW_RD2)
				rd_reg <= 1'b0;
			if (set_wr)
				wr_reg <= 1'b1;
			else if (state_next == PFSW_IDLE && state_reg != PFSW_IDLE
				&& !rd_reg)
				wr_reg <= 1'b0;
			// any other sfr write breaks the unlock sequence
			if (sfr_wr_i.wr_unlock && wd == `PFSW_UNLOCK_FIRST)
				unlock_reg <= 2'h1;
			else if (sfr_wr_i.wr_unlock && wd == `PFSW_UNLOCK_SECOND
				&& unlock_reg == 2'h1)
				unlock_reg <= 2'h2;
			// the control write that sets wr keeps it until the arm decision
			else if ((sfr_wr_i != '0 && !set_wr) || state_reg == PFSW_WSET1)
				unlock_reg <= 2'h0;
		end
	end

	// power-up timer holds off writes after reset
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pwrt_reg      <= 32'h0;
			pwrt_done_reg <= 1'b0;
		end else if (!pwrt_done_reg) begin
			pwrt_reg      <= pwrt_reg + 32'h1;
			pwrt_done_reg <= pwrt_reg >= PWRT_CYC - 1;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign flash_addr_low_o    = addr_lo_reg;
	assign flash_addr_high_o   = {4'h0, addr_hi_reg};
	assign flash_data_low_o    = data_reg[7:0];
	assign flash_data_high_o   = {2'h0, data_reg[13:8]};
	assign flash_control_o     = {1'b1, calibration_space_select_reg, 3'h0, write_enable_bit_reg,
		wr_reg, rd_reg};
	assign flash_unlock_port_o = 8'h00;
	assign discard_instr_o     = state_reg == PFSW_RD1;
	// clocks keep running; only instruction fetch waits
	assign cpu_stall_o = state_reg == PFSW_ERASE
		|| state_reg == PFSW_PROG;
	assign write_blocked_o = !pwrt_done_reg;
	assign arr_req_o.req   = state_reg == PFSW_RD2 || state_reg == PFSW_ERASE
		&& cnt_reg == 32'h0 || state_reg == PFSW_PROG;
	assign arr_req_o.erase = state_reg == PFSW_ERASE;
	assign arr_req_o.addr  = state_reg == PFSW_RD2 ? addr_w
		: {addr_w[12:2], (state_reg == PFSW_ERASE) ? 2'h0 : prog_slot_reg};
	assign arr_req_o.data  = buf_rdata;
	// test space reads go dark under code protection
	assign arr_req_o.test_space = calibration_space_select_reg && !code_protect_i;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_rd_two;
		@(posedge clk_i) disable iff (!nrst_i)
		(state_reg == PFSW_IDLE && rd_reg) |=> ##1 arr_req_o.req;
	endproperty
	a_rd_two: assert property (p_rd_two) else $error("read late");
	property p_unlock_zero;
		@(posedge clk_i) disable iff (!nrst_i)
		flash_unlock_port_o == 8'h00;
	endproperty
	a_unlock_zero: assert property (p_unlock_zero) else $error("unlock read");
	property p_no_arm;
		@(posedge clk_i) disable iff (!nrst_i)
		(state_reg == PFSW_IDLE && wr_reg && !write_enable_bit_reg) |=> !armed_reg;
	endproperty
	a_no_arm: assert property (p_no_arm) else $error("armed no write_enable_bit");
	property p_cal_block;
		@(posedge clk_i) disable iff (!nrst_i)
		(state_reg == PFSW_IDLE && wr_reg && calibration_space_select_reg) |=> !armed_reg;
	endproperty
	a_cal_block: assert property (p_cal_block) else $error("cal write");
	property p_erase_nib;
		@(posedge clk_i) disable iff (!nrst_i)
		(state_reg == PFSW_ERASE) |-> addr_lo_reg[3:0] == 4'h3;
	endproperty
	a_erase_nib: assert property (p_erase_nib) else $error("bad erase");
	property p_stall;
		@(posedge clk_i) disable iff (!nrst_i)
		(state_reg == PFSW_WSET2 && armed_reg && last_slot && row_erase)
			|=> cpu_stall_o && arr_req_o.req && arr_req_o.erase;
	endproperty
	a_stall: assert property (p_stall) else $error("no stall");
	property p_pwrt;
		@(posedge clk_i) disable iff (!nrst_i)
		write_blocked_o |-> !(state_reg == PFSW_WSET1 && armed_reg);
	endproperty
	a_pwrt: assert property (p_pwrt) else $error("pwrt write");
	property p_hold;
		@(posedge clk_i) disable iff (!nrst_i)
		(state_reg == PFSW_IDLE && !sfr_wr_i.wr_data_low
			&& !sfr_wr_i.wr_data_high) |=> $stable(data_reg);
	endproperty
	a_hold: assert property (p_hold) else $error("data lost");
endmodule // pfsw_ctrl
`default_nettype wire

// *** verif/pfsw_flash_model.sv ***
// flash array partner model for the self-write controller
`default_nettype none
module pfsw_flash_model
	import pfsw_pkg::*;
#(
	parameter int unsigned DONE_DLY = 2,
	parameter logic [13:0] CAL_WORD = 14'h2222
) (
	input  wire logic          clk_i,
	input  wire pfsw_arr_req_t req_i,
	input  wire logic          prog_i,
	output logic [13:0]        rdata_o,
	output logic               done_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------------------
	// array contents: word n starts as n xor 1555h
	// ------------------------------------------------------------
	logic [13:0] mem [4096];
	int unsigned cnt;
	initial begin
		for (int i = 0; i < 4096; i++) begin
			mem[i] = 14'(i) ^ 14'h1555;
		end
		cnt = 0;
		done_o = 1'b0;
	end
	// idle port shows the inverse so a stale word never passes as valid
	assign rdata_o = req_i.test_space ? CAL_WORD :
		req_i.req ? mem[req_i.addr[11:0]] : ~mem[req_i.addr[11:0]];
	// ------------------------------------------------------------
	// erase and program
	// ------------------------------------------------------------
	always @(posedge clk_i) begin
		done_o <= 1'b0;
		if (req_i.req && req_i.erase) begin
			for (int i = 0; i < 16; i++) begin
				mem[{req_i.addr[11:4], 4'(i)}] <= 14'h3fff;
			end
		end
		if (req_i.req && !req_i.erase && prog_i && !done_o) begin
			if (cnt == DONE_DLY) begin
				mem[req_i.addr[11:0]] <= req_i.data;
				done_o <= 1'b1;
				cnt <= 0;
			end else begin
				cnt <= cnt + 1;
			end
		end
	end
endmodule // pfsw_flash_model
`default_nettype wire

// *** verif/pfsw_ctrl_tb.sv ***
// self-checking bench for the flash self-write controller
`default_nettype none
module pfsw_ctrl_tb
	import pfsw_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	localparam int unsigned ERASE_CYC = 60;
	localparam logic [5:0] A_L = 6'h20, A_H = 6'h10, D_L = 6'h08;
	localparam logic [5:0] D_H = 6'h04, CTL = 6'h02, UNL = 6'h01;
	typedef struct packed { logic [12:0] a; logic [13:0] e; } pfsw_row_t;
	pfsw_row_t     rows [4] = '{'{13'h0000, 14'h1555}, '{13'h0123, 14'h1476},
		'{13'h0800, 14'h1d55}, '{13'h0fff, 14'h1aaa}};
	logic          clk = 1'b0;
	logic          nrst = 1'b0;
	pfsw_sfr_wr_t  sfr = '0;
	logic [1:0]    prot = 2'h0;
	logic          sprog = 1'b0, cprot = 1'b0;
	pfsw_arr_req_t req;
	logic [13:0]   rdata;
	logic          done, disc, stall, blk;
	logic [7:0]    a_lo, a_hi, d_lo, d_hi, ctl, unl;
	logic [7:0]    ctl_base = 8'h04;
	int            n_fail = 0, n_checks = 0, cyc = 0, stall_cnt = 0;

	pfsw_ctrl #(.ERASE_CYC(ERASE_CYC), .PWRT_CYC(50)) DUT (
		.clk_i(clk), .nrst_i(nrst), .sfr_wr_i(sfr), .protect_seg_i(prot),
		.serial_prog_i(sprog), .code_protect_i(cprot), .arr_rdata_i(rdata),
		.arr_done_i(done), .arr_req_o(req), .flash_addr_low_o(a_lo),
		.flash_addr_high_o(a_hi), .flash_data_low_o(d_lo),
		.flash_data_high_o(d_hi), .flash_control_o(ctl),
		.flash_unlock_port_o(unl), .discard_instr_o(disc),
		.cpu_stall_o(stall), .write_blocked_o(blk));
	pfsw_flash_model #(.DONE_DLY(2)) FLASH (.clk_i(clk), .req_i(req),
		.prog_i(stall), .rdata_o(rdata), .done_o(done));

	always #10 clk = ~clk;
	// a hang ends the run as a failure
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			results();
		end
	end
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic sfr_w(input logic [5:0] s, input logic [7:0] v);
		@(posedge clk);
		#1;
		sfr = {v, s};
		@(posedge clk);
		#1;
		sfr = '0;
	endtask
	task automatic wait_clr(input logic [7:0] m);
		stall_cnt = 0;
		for (int i = 0; i < 2000 && (ctl & m) != 8'h00; i++) begin
			@(posedge clk);
			#1;
			if (stall === 1'b1) stall_cnt++;
		end
		chk("req_bit_clear", 16'h0, {8'h0, ctl & m});
	endtask
	task automatic rd(input logic [12:0] a, input logic [13:0] e);
		sfr_w(A_H, {3'h0, a[12:8]});
		sfr_w(A_L, a[7:0]);
		@(posedge clk);
		#1;
		sfr = {ctl_base | 8'h01, CTL};
		@(posedge clk);
		#1;
		sfr = '0;
		chk("discard_c1", 16'h0, {15'h0, disc});
		@(posedge clk);
		#1;
		chk("discard_c2", 16'h1, {15'h0, disc});
		repeat (2) @(posedge clk);
		#1;
		chk("read_data", {2'h0, e}, {d_hi, d_lo});
		chk("addr_view", {3'h0, a}, {a_hi, a_lo});
		wait_clr(8'h01);
	endtask
	task automatic wrw(input logic [12:0] a, input logic [13:0] d,
		input logic [7:0] u2);
		sfr_w(A_H, {3'h0, a[12:8]});
		sfr_w(A_L, a[7:0]);
		sfr_w(D_L, d[7:0]);
		sfr_w(D_H, {2'h0, d[13:8]});
		sfr_w(UNL, 8'h55);
		sfr_w(UNL, u2);
		sfr_w(CTL, ctl_base | 8'h02);
		wait_clr(8'h02);
	endtask
	// word n of a block gets n + 0a00h
	task automatic blk_w(input logic [12:0] base);
		for (int i = 0; i < 4; i++) begin
			wrw(base + 13'(i), 14'(base) + 14'(i) + 14'h0a00, 8'haa);
			if (i < 3) chk("slot_no_stall", 16'h0, 16'(stall_cnt));
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// ------------------------------------------------------------
	// sequence
	// ------------------------------------------------------------
	initial begin
		repeat (6) @(posedge clk);
		#1;
		nrst = 1'b1;
		chk("control_rst", 16'h0080, {8'h0, ctl});
		chk("unlock_rst", 16'h0, {8'h0, unl});
		chk("blocked_rst", 16'h1, {15'h0, blk});
		sfr_w(CTL, 8'h04);
		wrw(13'h0003, 14'h0abc, 8'haa);
		chk("pwrt_word", 16'h1556, {2'h0, FLASH.mem[3]});
		for (int i = 0; i < 200 && blk !== 1'b0; i++) @(posedge clk);
		#1;
		chk("blocked_end", 16'h0, {15'h0, blk});
		$display("test reset done");
		foreach (rows[i]) rd(rows[i].a, rows[i].e);
		$display("test reads done");
		blk_w(13'h0010);
		chk("erase_stall", 16'h1, {15'h0, stall_cnt >= ERASE_CYC});
		for (int i = 0; i < 16; i++) begin
			chk("row_word", i < 4 ? 16'(i) + 16'h0a10 : 16'h3fff,
				{2'h0, FLASH.mem[16 + i]});
		end
		rd(13'h0012, 14'h0a12);
		chk("unlock_zero", 16'h0, {8'h0, unl});
		blk_w(13'h0024);
		chk("no_erase_stall", 16'h1, {15'h0, stall_cnt < ERASE_CYC});
		chk("no_erase_word", 16'h1575, {2'h0, FLASH.mem[32]});
		chk("prog_word", 16'h0a27, {2'h0, FLASH.mem[39]});
		// change one word; the others are read back and reloaded
		for (int i = 0; i < 4; i++) begin
			logic [13:0] w;
			w = i == 1 ? 14'h0bbb : 14'h0a24 + 14'(i);
			if (i != 1) rd(13'h0024 + 13'(i), w);
			wrw(13'h0024 + 13'(i), w, 8'haa);
		end
		chk("partial_new", 16'h0bbb, {2'h0, FLASH.mem[37]});
		chk("partial_kept", 16'h0a24, {2'h0, FLASH.mem[36]});
		$display("test block writes done");
		// bad unlock, no enable, calibration select, all protected
		for (int k = 0; k < 4; k++) begin
			ctl_base = k == 1 ? 8'h00 : (k == 2 ? 8'h44 : 8'h04);
			prot = k == 3 ? 2'h3 : 2'h0;
			sfr_w(CTL, ctl_base);
			wrw(13'h0033, 14'h0000, k == 0 ? 8'h55 : 8'haa);
			chk("refused_word", 16'h1566, {2'h0, FLASH.mem[51]});
			chk("refused_row", 16'h1565, {2'h0, FLASH.mem[48]});
		end
		ctl_base = 8'h04;
		sfr_w(CTL, ctl_base);
		rd(13'h0033, 14'h1566);
		// external programmer: protect bits ignored, code protect blocks
		sprog = 1'b1;
		wrw(13'h0037, 14'h0123, 8'haa);
		chk("serial_word", 16'h0123, {2'h0, FLASH.mem[55]});
		cprot = 1'b1;
		wrw(13'h0037, 14'h0321, 8'haa);
		chk("cp_serial_word", 16'h0123, {2'h0, FLASH.mem[55]});
		sprog = 1'b0;
		cprot = 1'b0;
		prot = 2'h0;
		ctl_base = 8'h40;
		rd(13'h0000, 14'h2222);
		cprot = 1'b1;
		rd(13'h0000, 14'h1555);
		cprot = 1'b0;
		$display("test refusals done");
		// a second power-up clears the enable and restarts the timer
		nrst = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		nrst = 1'b1;
		chk("control_rst2", 16'h0080, {8'h0, ctl});
		chk("blocked_rst2", 16'h1, {15'h0, blk});
		$display("test second reset done");
		results();
	end
endmodule // pfsw_ctrl_tb
`default_nettype wire
